// file: rtl/pwsq_top.sv
// Purpose: pwm and shared square-wave outputs on general purpose pins
// Assumes: configuration inputs come from logic on the same clock
// Notes:   pwm and square-wave settings take effect only at period boundaries
//          square duty: below 16'h8000 off, 16'h8000 or zero half,
//          above 16'h8000 on; a square half period of 0 stops it
//          pwm duty at or above the period holds the pin high
`timescale 1ns/100ps
// Operation
// - software sets the pwm period, shortest one microsecond, so up to 1 MHz.
// - pwm duty can be set from always low to always high over the period.
// - duty resolution equals the period length in one microsecond steps.
// - each of 16 pins may select the pwm function as its alternate function.
// - square-wave pins share one frequency but each keeps its own duty.
// - square frequency runs from stopped up to 4 MHz, half high half low.
module pwsq_top #(
    parameter int PINS = 16
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire pwsq_pkg::pwsq_pwm_cfg_type  pwm_cfg,
    input  wire logic [PINS-1:0][15:0]       pin_duty,
    input  wire pwsq_pkg::pwsq_sq_cfg_type   sq_cfg,
    input  wire logic [PINS-1:0][1:0]        pin_function,
    input  wire logic [PINS-1:0]             gpio_out,
    output logic [PINS-1:0]                  general_purpose_pin,
    output logic                             shared_square_wave_output
);
    localparam logic [6:0] STEP_LAST =
        7'(pwsq_pkg::STEP_CYCLES - 1);
    localparam logic [31:0] SQ_MIN = 32'(pwsq_pkg::SQ_MIN_HALF);
    localparam logic [15:0] PWM_MIN = 16'(pwsq_pkg::PWM_MIN_STEPS);
    localparam logic [15:0] SQ_PHASE_HIGH = 16'h7fff;
    localparam logic [15:0] SQ_PHASE_LOW  = 16'h8000;
    localparam logic [15:0] SQ_DUTY_HALF  = 16'h8000;

    // microsecond step prescaler and pwm period counter
    logic [6:0]  step_cnt;
    logic [6:0]  next_step_cnt;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] period;
    logic [15:0] next_period;
    logic        step;
    logic        wrap;

    always_comb begin
        step          = (step_cnt == STEP_LAST);
        next_step_cnt = step_cnt + 7'h01;
        if (step) begin
            next_step_cnt = 7'h00;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            step_cnt <= 7'h00;
        end else begin
            step_cnt <= next_step_cnt;
        end
    end

    always_comb begin
        wrap        = step && (count + 16'h0001 >= period);
        next_count  = count;
        next_period = period;
        if (wrap) begin
            next_count = 16'h0000;
        end else if (step) begin
            next_count = count + 16'h0001;
        end
        if (wrap) begin
            if (pwm_cfg.period < PWM_MIN) begin
                next_period = PWM_MIN;
            end else begin
                next_period = pwm_cfg.period;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count    <= 16'h0000;
            period   <= pwsq_pkg::PERIOD_RESET;
        end else begin
            count    <= next_count;
            period   <= next_period;
        end
    end

    // square wave: half period in clock cycles, zero stops it
    logic [31:0] half;
    logic [31:0] next_half;
    logic [31:0] half_cfg;
    logic [31:0] sq_cnt;
    logic [31:0] next_sq_cnt;
    logic        sq;
    logic        next_sq;
    logic        sq_edge;

    always_comb begin
        half_cfg = sq_cfg.half;
        if (sq_cfg.half != 32'h0 && sq_cfg.half < SQ_MIN) begin
            half_cfg = SQ_MIN;
        end
        sq_edge     = (sq_cnt + 32'h1 >= half);
        next_half   = half;
        next_sq_cnt = sq_cnt + 32'h1;
        next_sq     = sq;
        if (half == 32'h0) begin
            next_sq_cnt = 32'h0;
            next_sq     = 1'b0;
            next_half   = half_cfg;
        end else if (sq_edge) begin
            next_sq_cnt = 32'h0;
            next_sq     = ~sq;
            if (sq) begin
                next_half = half_cfg;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            half   <= pwsq_pkg::HALF_RESET;
            sq_cnt <= 32'h0;
            sq     <= 1'b0;
        end else begin
            half   <= next_half;
            sq_cnt <= next_sq_cnt;
            sq     <= next_sq;
        end
    end

    assign shared_square_wave_output = sq;

    // per pin duty on pwm and on the shared square frequency
    logic [PINS-1:0]       pwm_level;
    logic [PINS-1:0]       sq_level;
    logic                  sq_wrap;
    logic                  sq_load;
    logic [15:0]           sq_phase;
    logic [PINS-1:0][15:0] sq_duty;

    // square duty: below half is off, half follows, above half is on
    always_comb begin
        sq_wrap = sq_edge && sq && (half != 32'h0);
        // a stopped output keeps taking duty so a restart is clean
        sq_load = sq_wrap || (half == 32'h0);
        // phase of the half about to be driven, so pins track sq
        if (next_sq) begin
            sq_phase = SQ_PHASE_HIGH;
        end else begin
            sq_phase = SQ_PHASE_LOW;
        end
        for (int i = 0; i < PINS; i++) begin
            sq_duty[i] = pin_duty[i];
            if (pin_duty[i] == 16'h0000) begin
                sq_duty[i] = SQ_DUTY_HALF;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : gen_pin
            // next count keeps the level in step at the wrap
            pwsq_channel u_pwm (
                .clock   (clock),
                .nrst    (nrst),
                .wrap    (wrap),
                .count   (next_count),
                .duty_in (pin_duty[g]),
                .level   (pwm_level[g])
            );
            pwsq_channel u_sq (
                .clock   (clock),
                .nrst    (nrst),
                .wrap    (sq_load),
                .count   (sq_phase),
                .duty_in (sq_duty[g]),
                .level   (sq_level[g])
            );
        end
    endgenerate

    logic [PINS-1:0] next_pins;

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            case (pin_function[i])
                2'(pwsq_pkg::PWSQ_FN_PWM): begin
                    next_pins[i] = pwm_level[i];
                end
                2'(pwsq_pkg::PWSQ_FN_SQUARE): begin
                    next_pins[i] = sq_level[i];
                end
                2'(pwsq_pkg::PWSQ_FN_GPIO): begin
                    next_pins[i] = gpio_out[i];
                end
                // the spare code also gives the plain output
                default: begin
                    next_pins[i] = gpio_out[i];
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            general_purpose_pin <= '0;
        end else begin
            general_purpose_pin <= next_pins;
        end
    end
endmodule

// file: rtl/pwsq_pkg.sv
// Purpose: shared constants and carriers for the pwm and square-wave block
// Assumes: 100 MHz system clock
// Notes:   square half periods are counted in system clock cycles, pwm periods in one microsecond steps
package pwsq_pkg;

    localparam int unsigned CLOCK_HZ       = 100000000;
    localparam int unsigned PWM_MAX_HZ     = 1000000;
    localparam int unsigned SQ_MAX_HZ      = 4000000;
    localparam int unsigned STEP_NS        = 1000;
    localparam int unsigned CLOCK_NS       = 10;
    // one duty step is one microsecond
    localparam int unsigned STEP_CYCLES    = STEP_NS / CLOCK_NS;
    // shortest pwm period in steps, and shortest square half period in cycles
    localparam int unsigned PWM_MIN_STEPS  = 1;
    // rounded up so the square output never passes its top rate
    localparam int unsigned SQ_MIN_HALF    =
        (CLOCK_HZ + 2 * SQ_MAX_HZ - 1) / (2 * SQ_MAX_HZ);
    localparam int unsigned PINS           = 16;
    localparam int unsigned PERIOD_W       = 16;
    localparam logic [15:0] PERIOD_RESET   = 16'h0001;
    localparam logic [15:0] DUTY_RESET     = 16'h0000;
    localparam logic [31:0] HALF_RESET     = 32'h0000_0000;

    typedef enum logic [1:0] {
        PWSQ_FN_GPIO,
        PWSQ_FN_PWM,
        PWSQ_FN_SQUARE
    } pwsq_fn_type;

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] duty;
    } pwsq_pwm_cfg_type;

    typedef struct packed {
        logic [31:0] half;
    } pwsq_sq_cfg_type;

endpackage

// file: rtl/pwsq_channel.sv
// Purpose: one pin's pwm comparator with period-end duty loading
// Assumes: period wrap and count come from the shared counter
// Notes:   duty equal or above period gives constant high
`timescale 1ns/100ps
module pwsq_channel (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        wrap,
    input  wire logic [15:0] count,
    input  wire logic [15:0] duty_in,
    output logic             level
);
    logic [15:0] duty;
    logic [15:0] next_duty;
    logic        next_level;

    always_comb begin
        next_duty = duty;
        if (wrap) begin
            next_duty = duty_in;
        end
        next_level = (count < next_duty);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            duty  <= pwsq_pkg::DUTY_RESET;
            level <= 1'b0;
        end else begin
            duty  <= next_duty;
            level <= next_level;
        end
    end
endmodule

// file: sim/pwsq_load.sv
// Purpose: external load timing pulses on one pin
// Assumes: pin sampled on the system clock
// Notes:   figures latch at each rising edge of the pin
`timescale 1ns/100ps
module pwsq_load (
    input  wire logic  clock,
    input  wire logic  pin,
    output logic [15:0] period,
    output logic [15:0] high,
    output int          rises
);
    logic [15:0] run = '0;
    logic [15:0] run_high = '0;
    logic        last = 1'b0;
    initial begin
        period = '0;
        high = '0;
        rises = 0;
    end
    always @(posedge clock) begin
        last <= pin;
        if (pin && !last) begin
            period <= run;
            high <= run_high;
            rises <= rises + 1;
            run <= 16'h0001;
            run_high <= 16'h0001;
        end else begin
            run <= run + 16'h0001;
            run_high <= run_high + {15'h0000, pin};
        end
    end
endmodule

// file: sim/pwsq_asserts.sv
// Purpose: port checks for pwsq_top
// Assumes: pin 0 is watched
// Notes:   pwm figures only once config is calm
`timescale 1ns/100ps
module pwsq_asserts #(
    parameter int PINS = 16
) (
    input wire logic                       clock,
    input wire logic                       nrst,
    input wire pwsq_pkg::pwsq_pwm_cfg_type pwm_cfg,
    input wire logic [PINS-1:0][15:0]      pin_duty,
    input wire logic [PINS-1:0][1:0]       pin_function,
    input wire logic [PINS-1:0]            gpio_out,
    input wire logic [PINS-1:0]            general_purpose_pin,
    input wire logic                       shared_square_wave_output
);
    logic [11:0] calm;
    logic [15:0] gap;
    logic [15:0] hi;
    logic        pin;
    logic        sq;
    logic        ok;
    logic [15:0] per;
    logic [15:0] dut;
    assign pin = general_purpose_pin[0];
    assign sq = shared_square_wave_output;
    assign per = pwm_cfg.period;
    assign dut = pin_duty[0];
    assign ok = calm[11] && per <= 16'h000a && dut != 16'h0000 && dut < per;
    // calm saturates after 2048 clock cycles of unchanged pwm settings
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            calm <= '0;
            gap <= '0;
            hi <= '0;
        end else begin
            calm <= (pin_function[0] == 2'h1 && $stable(pwm_cfg)
                && $stable(dut)) ? calm + {11'h000, !calm[11]} : '0;
            gap <= $rose(pin) ? 16'h0001 : gap + 16'h0001;
            hi <= $rose(pin) ? 16'h0001 : hi + {15'h0000, pin};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    gap_len_a: assert property (ok && $rose(pin)
        |-> gap == per * 16'h0064) else $error("pwm period wrong");
    duty_ends_a: assert property (calm[11] && per != 16'h0000
        && per <= 16'h000a && (dut == 16'h0000 || dut >= per)
        |-> pin == (dut != 16'h0000)) else $error("pwm end duty wrong");
    high_time_a: assert property (ok && $fell(pin)
        |-> hi == dut * 16'h0064) else $error("pwm high time wrong");
    gpio_route_a: assert property ((pin_function[0] == 2'h0
        && gpio_out[0])[*3] |-> pin) else $error("gpio path wrong");
    sq_follow_a: assert property ($rose(pin) && dut == 16'h0000
        && pin_function[0] == 2'h2 && $past(pin_function[0], 2) == 2'h2
        |-> sq) else $error("square pin off shared");
    sq_high_a: assert property ($rose(sq) |=> sq[*8])
        else $error("square high too short");
    sq_low_a: assert property ($fell(sq) |=> !sq[*8])
        else $error("square low too short");
endmodule
bind pwsq_top pwsq_asserts #(.PINS(PINS)) u_pwsq_asserts (
    .clock(clock), .nrst(nrst), .pwm_cfg(pwm_cfg), .pin_duty(pin_duty),
    .pin_function(pin_function), .gpio_out(gpio_out),
    .general_purpose_pin(general_purpose_pin),
    .shared_square_wave_output(shared_square_wave_output));

// file: sim/pwsq_top_bench.sv
// Purpose: self-checking bench for pwsq_top
// Assumes: 100 MHz clock
// Notes:   pin 0 is timed by the load model
`timescale 1ns/100ps
module pwsq_top_bench;
    logic                       clock;
    logic                       nrst;
    pwsq_pkg::pwsq_pwm_cfg_type pwm_cfg;
    pwsq_pkg::pwsq_sq_cfg_type  sq_cfg;
    logic [15:0][15:0]          pin_duty;
    logic [15:0][1:0]           pin_function;
    logic [15:0]                gpio_out;
    logic [15:0]                pins;
    logic                       sq;
    logic [15:0]                period;
    logic [15:0]                high;
    int                         rises;
    int                         errors = 0;
    int                         total_checks = 0;
    int                         cycles = 0;
    pwsq_top u_pwsq_top (.clock(clock), .nrst(nrst), .pwm_cfg(pwm_cfg),
        .pin_duty(pin_duty), .sq_cfg(sq_cfg), .pin_function(pin_function),
        .gpio_out(gpio_out), .general_purpose_pin(pins),
        .shared_square_wave_output(sq));
    pwsq_load u_pwsq_load (.clock(clock), .pin(pins[0]), .period(period),
        .high(high), .rises(rises));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    // waits n rises of pin 0, then compares the last pulse
    task automatic wave(string what, logic [15:0] p, logic [15:0] h, int n);
        int goal;
        goal = rises + n;
        while (rises < goal) @(posedge clock);
        #1;
        check({what, " period"}, period, p);
        check({what, " high"}, high, h);
    endtask
    task automatic pwm_rates();
        logic [15:0][15:0] d;
        d = {16{16'h0003}};
        d[1] = 16'h0000;
        d[2] = 16'h000a;
        @(posedge clock);
        pwm_cfg <= {16'h000a, 16'h0000};
        pin_duty <= d;
        pin_function <= {16{2'h1}};
        wave("pwm 100k", 16'h03e8, 16'h012c, 3);
        check("pwm pins", pins, 16'hfffd);
        repeat (400) @(posedge clock);
        pwm_cfg <= {16'h0004, 16'h0000};
        pin_duty <= {16{16'h0002}};
        wave("pwm held", 16'h03e8, 16'h012c, 1);
        wave("pwm new", 16'h0190, 16'h00c8, 1);
        @(posedge clock);
        pwm_cfg <= {16'h0002, 16'h0000};
        pin_duty <= {16{16'h0001}};
        wave("pwm 500k", 16'h00c8, 16'h0064, 3);
        @(posedge clock);
        pin_duty <= '0;
        repeat (2100) @(posedge clock);
        #1;
        check("pwm off", pins, 16'h0000);
    endtask
    task automatic square_wave();
        logic [15:0][15:0] d;
        d = '0;
        d[1] = 16'h0001;
        @(posedge clock);
        pin_duty <= d;
        pin_function <= {16{2'h2}};
        sq_cfg <= 32'h0000_0005;
        wave("sq clamp", 16'h001a, 16'h000d, 3);
        @(posedge clock);
        sq_cfg <= 32'h0000_0032;
        wave("sq 1m", 16'h0064, 16'h0032, 3);
        check("sq pins", {14'h0000, pins[1:0]}, 16'h0001);
        @(posedge clock);
        sq_cfg <= '0;
        repeat (100) @(posedge clock);
        #1;
        check("sq stop", {15'h0000, sq}, 16'h0000);
    endtask
    initial begin
        nrst = 1'b0;
        pwm_cfg = '0;
        sq_cfg = '0;
        pin_duty = '0;
        pin_function = '0;
        gpio_out = '0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        pwm_rates();
        square_wave();
        @(posedge clock);
        pin_function <= '0;
        gpio_out <= 16'ha5c3;
        repeat (4) @(posedge clock);
        #1;
        check("gpio", pins, 16'ha5c3);
        give_verdict();
    end
endmodule
